// ==== src/pstc_pkg.sv ====
// Purpose: Shared constants and types of the pulse-synced timestamp clock
// Assumes: sys_clk at 125 MHz; all inputs synchronous to it
// Notes:   Fraction keeps 27 active bits; the five bits below read zero
package pstc_pkg;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned SEC_NS        = 1000000000;
   localparam int unsigned CYC_PER_SEC   = SEC_NS / CLK_PERIOD_NS;
   // Pulse acceptance window around one second
   localparam int unsigned PULSE_TOL_NS  = 100000;
   localparam int unsigned TOL_CYC       = PULSE_TOL_NS / CLK_PERIOD_NS;
   localparam int unsigned INTV_W        = 29;

   // Timestamp layout
   localparam int unsigned SEC_W      = 32;
   localparam int unsigned FRAC_W     = 32;
   localparam int unsigned FRAC_ACT   = 27;
   localparam int unsigned FRAC_ZERO  = FRAC_W - FRAC_ACT;
   localparam int unsigned SUB_W      = 32;
   localparam int unsigned ACC_W      = FRAC_ACT + SUB_W;
   localparam int unsigned INC_W      = 34;
   // 2^59 / 125e6: accumulator step for one 8 ns tick
   localparam logic [33:0] INC_NOM    = 34'h1_12E0_BE82;
   localparam int unsigned TRIM_SHIFT = 2;

   // Health
   localparam int unsigned THR_W          = 20;
   localparam logic [19:0] THR_DEFAULT_NS = 20'h00254;
   // ns to 2^-27 s units: x * 8796 / 2^16
   localparam logic [13:0] NS_TO_FRAC     = 14'h225C;
   localparam int unsigned NS_FRAC_SHIFT  = 16;
   localparam logic [3:0]  HEALTH_SECS    = 4'hA;
   localparam logic [31:0] RESYNC_LIMIT_S = 32'h0000_0001;

   typedef enum logic [2:0] {
      IN_NONE                         = 3'b000,
      IN_SERIAL_PULSE_INPUT_SELECT    = 3'b001,
      IN_INTERNAL                     = 3'b010,
      IN_HOST                         = 3'b011,
      IN_AUX                          = 3'b100
   } pstc_in_sel_t;

   typedef enum logic [2:0] {
      OUT_NONE                = 3'b000,
      OUT_REPEAT_PULSE_OUTPUT = 3'b001,
      OUT_LOOP                = 3'b010,
      OUT_INTERNAL            = 3'b011,
      OUT_HOST                = 3'b100
   } pstc_out_sel_t;

   typedef struct packed {
      logic [31:0] sec;
      logic [31:0] frac;
   } pstc_ts_t;

   // One-cycle command strobes
   typedef struct packed {
      logic setTime;
      logic fullReset;
      logic useDefault;
      logic deselect;
      logic selectIn;
      logic selectOut;
      logic loadThreshold;
      logic clearStats;
      logic driverLoad;
   } pstc_cmd_t;

   typedef struct packed {
      logic [31:0] total;
      logic [31:0] bad;
      logic [31:0] failures;
      logic [31:0] resyncs;
      logic [26:0] worstPhase;
   } pstc_stats_t;

endpackage

// ==== src/pstc_pulse_qual.sv ====
// Purpose: Judge reference pulses by their spacing from the previous good one
// Assumes: Pulse input is synchronous to sys_clk
// Notes:   First edge after restart has no predecessor and is taken as good
`timescale 1ns/10ps
`default_nettype none
module pstc_pulse_qual #(
   parameter int unsigned CYC_PER_SEC = pstc_pkg::CYC_PER_SEC,
   parameter int unsigned TOL_CYC     = pstc_pkg::TOL_CYC
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic restart,
   input  wire logic pulseIn,
   output logic      rise,
   output logic      good,
   output logic      bad
);
   localparam logic [28:0] LO = 29'(CYC_PER_SEC - TOL_CYC);
   localparam logic [28:0] HI = 29'(CYC_PER_SEC + TOL_CYC);

   logic        pulseDly;
   logic        armed;
   logic [28:0] interval;
   logic        inWindow;

   assign rise     = pulseIn & ~pulseDly;
   assign inWindow = (interval >= LO) && (interval <= HI);
   // A stray edge does not restart the interval, so noise cannot
   // shift the expected arrival of the true pulse
   assign good     = rise & (~armed | inWindow);
   assign bad      = rise & armed & ~inWindow;

   always_ff @(posedge sys_clk) begin
      if (!rst_n || restart) begin
         pulseDly <= 1'b0;
         armed    <= 1'b0;
         interval <= '0;
      end else begin
         pulseDly <= pulseIn;
         if (good) begin
            armed    <= 1'b1;
            interval <= 29'h0000001;
         end else if (interval != '1) begin
            interval <= interval + 29'h0000001;
         end
      end
   end
endmodule // pstc_pulse_qual
`default_nettype wire

// ==== src/pstc_clock.sv ====
// Purpose: Time-of-day clock for packet stamps, steered by a second pulse
// Assumes: Host supplies its seconds with a strobe once per second
// Notes:   Stamps are 32.32 fixed point; only 27 fraction bits move
// Operation
// - Load host time, then free-run on crystal
// - Accept second pulse on serial input
// - Per-second host compare; over one second reloads
// - Capture stamp at each packet arrival
// - Stamp is 64-bit seconds since 1970
// - High word seconds, low word binary fraction
// - Only 27 fraction bits active, rest zero
// - Input select: serial, internal, host, auxiliary
// - Output select: repeat, loop, internal, host, none; host stays silent
// - Default serial in, no out; deselect clears
// - Set loads host time, clears statistics
// - Full reset loads time, defaults selects, clears
// - Statistics zeroed on load, clear, set, reset
// - Health threshold programmable, default 596 ns
// - Ten seconds over threshold: sync lost, counted
// - Badly spaced pulses rejected, counted apart
// - Count resyncs when error exceeds one second
`timescale 1ns/10ps
`default_nettype none
module pstc_clock #(
   parameter int unsigned CYC_PER_SEC = pstc_pkg::CYC_PER_SEC,
   parameter int unsigned TOL_CYC     = pstc_pkg::TOL_CYC
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire pstc_pkg::pstc_cmd_t     cmd,
   input  wire pstc_pkg::pstc_in_sel_t  inSelValue,
   input  wire pstc_pkg::pstc_out_sel_t outSelValue,
   input  wire logic [19:0]             thrNsValue,
   input  wire logic                    syncEnable,
   input  wire logic [31:0]             hostSec,
   input  wire logic                    hostSecTick,
   input  wire logic                    serialPulseIn,
   input  wire logic                    internalPulseIn,
   input  wire logic                    hostPulseIn,
   input  wire logic                    auxPulseIn,
   input  wire logic                    pktArrive,
   output pstc_pkg::pstc_ts_t           cardTime,
   output pstc_pkg::pstc_ts_t           pktStamp,
   output logic                         pktStampValid,
   output logic                         pulseOut,
   output pstc_pkg::pstc_in_sel_t       inSel,
   output pstc_pkg::pstc_out_sel_t      outSel,
   output logic [19:0]                  threshold,
   output logic                         synced,
   output logic                         acquiring,
   output logic signed [26:0]           phaseErr,
   output pstc_pkg::pstc_stats_t        stats
);
   // Time state
   logic [31:0] sec;
   logic [58:0] acc;
   logic [33:0] inc;
   logic [3:0]  overSecs;

   // Decode
   logic        selPulse;
   logic        pulseRise;
   logic        goodPulse;
   logic        badPulse;
   logic        restart;
   logic        hostMismatch;
   logic        reload;
   logic        statClear;
   logic [59:0] accSum;
   logic [26:0] frac27;
   logic signed [26:0] err;
   logic signed [26:0] errHalf;
   logic [26:0] errAbs;
   logic [33:0] thrProd;
   logic [26:0] thrFrac;
   logic        overThr;
   logic signed [31:0] hostDiff;
   logic [31:0] hostDiffAbs;
   logic [33:0] trimStep;
   logic        nextPulseOut;
   logic        secondTick;

   assign accSum = {1'b0, acc} + {26'h0, inc};
   assign frac27 = acc[58:32];
   assign secondTick = accSum[59];

   // Input mux; host and auxiliary lines pass through like serial and internal
   assign selPulse =
      (inSel == pstc_pkg::IN_SERIAL_PULSE_INPUT_SELECT) ? serialPulseIn :
      (inSel == pstc_pkg::IN_INTERNAL) ? internalPulseIn :
      (inSel == pstc_pkg::IN_HOST)     ? hostPulseIn :
      (inSel == pstc_pkg::IN_AUX)      ? auxPulseIn : 1'b0;

   // Card behind the pulse shows a fraction near one, i.e. negative
   assign err     = $signed(frac27);
   assign errHalf = err >>> 1;
   assign errAbs  = err[26] ? 27'(-err) : 27'(err);

   // Operands widened first so the product keeps all 34 bits
   assign thrProd = {14'h0000, threshold} * {20'h00000, pstc_pkg::NS_TO_FRAC};
   assign thrFrac = 27'(thrProd >> pstc_pkg::NS_FRAC_SHIFT);
   assign overThr = errAbs > thrFrac;

   assign hostDiff    = $signed(hostSec - sec);
   assign hostDiffAbs = hostDiff[31] ? 32'(-hostDiff) : 32'(hostDiff);
   assign hostMismatch = syncEnable & hostSecTick &
                         (hostDiffAbs > pstc_pkg::RESYNC_LIMIT_S);

   assign reload    = cmd.setTime | cmd.fullReset | hostMismatch;
   assign restart   = reload;
   assign statClear = cmd.driverLoad | cmd.clearStats |
                      cmd.setTime | cmd.fullReset;

   // Integral rate trim; gain below unity keeps the loop damped
   assign trimStep = 34'($signed(err)) <<< pstc_pkg::TRIM_SHIFT;

   pstc_pulse_qual #(
      .CYC_PER_SEC (CYC_PER_SEC),
      .TOL_CYC     (TOL_CYC)
   ) u_qual (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .restart (restart),
      .pulseIn (selPulse),
      .rise    (pulseRise),
      .good    (goodPulse),
      .bad     (badPulse)
   );

   // Time keeping
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sec       <= '0;
         acc       <= '0;
         inc       <= pstc_pkg::INC_NOM;
         acquiring <= 1'b1;
      end else if (reload) begin
         sec       <= hostSec;
         acc       <= '0;
         acquiring <= 1'b1;
      end else if (goodPulse && acquiring) begin
         // Snap to the pulse edge; round the seconds to the near side
         acc       <= '0;
         sec       <= err[26] ? sec + 32'h1 : sec;
         acquiring <= 1'b0;
      end else if (goodPulse) begin
         acc <= {27'(frac27 - errHalf), acc[31:0]};
         inc <= inc - trimStep;
      end else begin
         acc <= accSum[58:0];
         sec <= secondTick ? sec + 32'h1 : sec;
      end
   end

   assign cardTime.sec  = sec;
   assign cardTime.frac = {frac27, 5'h00};

   // Packet stamp: seconds high, fraction low, one word
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pktStamp      <= '0;
         pktStampValid <= 1'b0;
      end else begin
         pktStampValid <= pktArrive;
         if (pktArrive) begin
            pktStamp.sec  <= sec;
            pktStamp.frac <= {frac27, 5'h00};
         end
      end
   end

   // Selectors and threshold; lost on any logic reload
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         inSel     <= pstc_pkg::IN_SERIAL_PULSE_INPUT_SELECT;
         outSel    <= pstc_pkg::OUT_NONE;
         threshold <= pstc_pkg::THR_DEFAULT_NS;
      end else if (cmd.fullReset || cmd.useDefault) begin
         inSel  <= pstc_pkg::IN_SERIAL_PULSE_INPUT_SELECT;
         outSel <= pstc_pkg::OUT_NONE;
      end else if (cmd.deselect) begin
         inSel  <= pstc_pkg::IN_NONE;
         outSel <= pstc_pkg::OUT_NONE;
      end else begin
         if (cmd.selectIn)
            inSel <= inSelValue;
         if (cmd.selectOut)
            outSel <= outSelValue;
         if (cmd.loadThreshold)
            threshold <= thrNsValue;
      end
   end

   // Pulse output; host choice stays silent
   assign nextPulseOut =
      (outSel == pstc_pkg::OUT_REPEAT_PULSE_OUTPUT) ? serialPulseIn :
      (outSel == pstc_pkg::OUT_LOOP)     ? selPulse :
      (outSel == pstc_pkg::OUT_INTERNAL) ? secondTick : 1'b0;

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         pulseOut <= 1'b0;
      else
         pulseOut <= nextPulseOut;
   end

   // Phase error at the last good pulse and health judgement
   always_ff @(posedge sys_clk) begin
      if (!rst_n || reload) begin
         phaseErr <= '0;
         overSecs <= '0;
         synced   <= 1'b0;
      end else if (goodPulse && !acquiring) begin
         phaseErr <= err;
         if (!overThr) begin
            overSecs <= '0;
            synced   <= 1'b1;
         end else if (overSecs == pstc_pkg::HEALTH_SECS - 4'h1) begin
            synced   <= 1'b0;
            overSecs <= '0;
         end else begin
            overSecs <= overSecs + 4'h1;
         end
      end
   end

   // Statistics; an event in the clearing cycle is still counted
   logic lossEvent;
   assign lossEvent = goodPulse & ~acquiring & overThr & synced &
                      (overSecs == pstc_pkg::HEALTH_SECS - 4'h1);

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stats <= '0;
      end else begin
         stats.total <= (statClear ? 32'h0 : stats.total) +
                        {31'h0, pulseRise};
         stats.bad <= (statClear ? 32'h0 : stats.bad) +
                      {31'h0, badPulse};
         stats.failures <= (statClear ? 32'h0 : stats.failures) +
                           {31'h0, lossEvent};
         stats.resyncs <= (statClear ? 32'h0 : stats.resyncs) +
                          {31'h0, hostMismatch};
         if (goodPulse && !acquiring &&
             (statClear || errAbs > stats.worstPhase))
            stats.worstPhase <= errAbs;
         else if (statClear)
            stats.worstPhase <= '0;
      end
   end
endmodule // pstc_clock
`default_nettype wire

// ==== testbench/pstc_pps_src.sv ====
// Purpose: Second-pulse source standing in for the time receiver
// Assumes: Period counted in sys_clk cycles
// Notes:   Period zero parks the line low, as an idle receiver does
`timescale 1ns/10ps
`default_nettype none
module pstc_pps_src (
   input  wire logic        sys_clk,
   input  wire logic [15:0] period,
   output logic             pulse
);
   logic [15:0] phase = 16'h0000;

   always_ff @(posedge sys_clk) begin
      if (period == 16'h0000) begin
         phase <= 16'h0000;
         pulse <= 1'b0;
      end else begin
         phase <= (phase >= period - 16'h0001) ? 16'h0000 : phase + 16'h0001;
         pulse <= (phase < 16'h0004);
      end
   end
endmodule // pstc_pps_src
`default_nettype wire

// ==== testbench/pstc_monitor.sv ====
// Purpose: Port checker for pstc_clock
// Assumes: One clock domain, synchronous reset
// Notes:   Bound into every pstc_clock instance
`timescale 1ns/10ps
`default_nettype none
module pstc_monitor #(
   parameter int unsigned CYC_PER_SEC = 1000,
   parameter int unsigned TOL_CYC     = 10
) (
   input wire logic                    sys_clk,
   input wire logic                    rst_n,
   input wire pstc_pkg::pstc_cmd_t     cmd,
   input wire logic [19:0]             thrNsValue,
   input wire logic                    syncEnable,
   input wire logic [31:0]             hostSec,
   input wire logic                    hostSecTick,
   input wire logic                    serialPulseIn,
   input wire logic                    pktArrive,
   input wire pstc_pkg::pstc_ts_t      cardTime,
   input wire pstc_pkg::pstc_ts_t      pktStamp,
   input wire logic                    pktStampValid,
   input wire logic                    pulseOut,
   input wire pstc_pkg::pstc_in_sel_t  inSel,
   input wire pstc_pkg::pstc_out_sel_t outSel,
   input wire logic [19:0]             threshold,
   input wire logic                    acquiring,
   input wire pstc_pkg::pstc_stats_t   stats
);
   logic [31:0] hostDiff;
   logic        bigDiff;
   // Difference wraps, so both signs are judged from one subtraction
   assign hostDiff = hostSec - cardTime.sec;
   assign bigDiff  = hostDiff[31] ? (hostDiff < 32'hFFFFFFFF)
                                  : (hostDiff > 32'h00000001);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence sHostTick;
      syncEnable && hostSecTick && cmd == '0;
   endsequence
   sequence sSerialRise;
      $rose(serialPulseIn) && cmd == '0
      && inSel == pstc_pkg::IN_SERIAL_PULSE_INPUT_SELECT;
   endsequence
   AST_LOW_FRAC: assert property (
      cardTime.frac[4:0] == 5'h00 && pktStamp.frac[4:0] == 5'h00)
      else $error("low fraction bits set");
   AST_PKT_STAMP: assert property (
      pktArrive |=> pktStampValid && pktStamp == $past(cardTime))
      else $error("packet stamp wrong");
   AST_SET: assert property (
      cmd.setTime |=> cardTime.sec == $past(hostSec)
      && cardTime.frac == 32'h0 && stats == '0)
      else $error("set command wrong");
   AST_FULL_RESET: assert property (
      cmd.fullReset |=> cardTime.sec == $past(hostSec) && stats == '0
      && inSel == pstc_pkg::IN_SERIAL_PULSE_INPUT_SELECT
      && outSel == pstc_pkg::OUT_NONE)
      else $error("full reset wrong");
   AST_DESELECT: assert property (
      cmd.deselect && !cmd.fullReset && !cmd.useDefault
      |=> inSel == pstc_pkg::IN_NONE && outSel == pstc_pkg::OUT_NONE)
      else $error("deselect wrong");
   AST_THRESH: assert property (
      cmd.loadThreshold && !cmd.fullReset && !cmd.useDefault
      && !cmd.deselect |=> threshold == $past(thrNsValue))
      else $error("threshold not loaded");
   AST_CLEAR: assert property (
      cmd.clearStats || cmd.driverLoad |=> stats == '0)
      else $error("statistics not cleared");
   AST_RELOAD: assert property (
      sHostTick ##0 bigDiff |=> cardTime.sec == $past(hostSec)
      && acquiring && stats.resyncs == $past(stats.resyncs) + 32'h1)
      else $error("host reload wrong");
   AST_COUNT: assert property (
      sSerialRise |=> stats.total == $past(stats.total) + 32'h1)
      else $error("pulse not counted");
   AST_REPEAT: assert property (
      outSel == pstc_pkg::OUT_REPEAT_PULSE_OUTPUT
      |=> pulseOut == $past(serialPulseIn))
      else $error("repeat output wrong");
endmodule // pstc_monitor
bind pstc_clock pstc_monitor #(.CYC_PER_SEC(CYC_PER_SEC), .TOL_CYC(TOL_CYC))
   mon (.sys_clk, .rst_n, .cmd, .thrNsValue, .syncEnable, .hostSec,
        .hostSecTick, .serialPulseIn, .pktArrive, .cardTime, .pktStamp,
        .pktStampValid, .pulseOut, .inSel, .outSel, .threshold,
        .acquiring, .stats);
`default_nettype wire

// ==== testbench/test_pstc_clock.sv ====
// Purpose: Self-checking bench for pstc_clock
// Assumes: Pulse second shortened to 1000 cycles; card time still runs at 8 ns per tick
// Notes:   Ten-second health loss is left to the long runs
`timescale 1ns/10ps
`default_nettype none
module test_pstc_clock;
   logic                    sys_clk, rst_n = 1'b0, pktArrive = 1'b0;
   logic                    syncEnable = 1'b0, hostSecTick = 1'b0;
   logic                    hostPulseIn = 1'b0, auxPulseIn = 1'b0;
   logic                    internalPulseIn, serialPulseIn, pktStampValid;
   logic                    pulseOut, synced, acquiring;
   logic [19:0]             thrNsValue = 20'h00000, threshold;
   logic [31:0]             hostSec = 32'h00000000;
   logic [15:0]             period = 16'h0000;
   logic signed [26:0]      phaseErr;
   pstc_pkg::pstc_cmd_t     cmd = '0;
   pstc_pkg::pstc_in_sel_t  inSelValue = pstc_pkg::IN_NONE, inSel;
   pstc_pkg::pstc_out_sel_t outSelValue = pstc_pkg::OUT_NONE, outSel;
   pstc_pkg::pstc_ts_t      cardTime, pktStamp;
   pstc_pkg::pstc_stats_t   stats;
   int                      failures = 0, n_checks = 0;

   assign internalPulseIn = serialPulseIn;
   pstc_clock #(.CYC_PER_SEC(1000), .TOL_CYC(10)) DUT (
      .sys_clk, .rst_n, .cmd, .inSelValue, .outSelValue, .thrNsValue,
      .syncEnable, .hostSec, .hostSecTick, .serialPulseIn, .internalPulseIn,
      .hostPulseIn, .auxPulseIn, .pktArrive, .cardTime, .pktStamp,
      .pktStampValid, .pulseOut, .inSel, .outSel, .threshold, .synced,
      .acquiring, .phaseErr, .stats);
   pstc_pps_src src (.sys_clk, .period, .pulse(serialPulseIn));

   task automatic chk(input string w, input logic [63:0] s, e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic final_report;
      $display("Checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic go(input logic [8:0] m, input logic [2:0] si = 3'h0,
                     input logic [2:0] so = 3'h0,
                     input logic [19:0] th = 20'h00000);
      @(posedge sys_clk);
      cmd         <= pstc_pkg::pstc_cmd_t'(m);
      inSelValue  <= pstc_pkg::pstc_in_sel_t'(si);
      outSelValue <= pstc_pkg::pstc_out_sel_t'(so);
      thrNsValue  <= th;
      @(posedge sys_clk);
      cmd <= '0;
      #1;
   endtask
   task automatic do_reset;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      tick(5);
      rst_n <= 1'b1;
      #1;
      chk("reset sel", {inSel, outSel}, 6'h08);
      chk("reset thr", threshold, 20'h00254);
      chk("reset stats", stats === '0, 1'b1);
      chk("reset acquiring", acquiring, 1'b1);
   endtask
   task automatic t_set;
      @(posedge sys_clk);
      hostSec <= 32'h5F000000;
      go(9'h100);
      chk("set sec", cardTime.sec, 32'h5F000000);
      chk("set frac", cardTime.frac, 32'h00000000);
      tick(125);
      #1;
      // 125 ticks of 8 ns make 1 us, about 10C7 in the low word
      chk("free run", cardTime.frac >= 32'h00001000
          && cardTime.frac <= 32'h00001200, 1'b1);
   endtask
   task automatic t_packet;
      pstc_pkg::pstc_ts_t e;
      @(posedge sys_clk);
      pktArrive <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         @(negedge sys_clk);
         e = cardTime;
         @(posedge sys_clk);
         pktArrive <= (i == 0);
         #1;
         chk("stamp valid", pktStampValid, 1'b1);
         chk("stamp", pktStamp, e);
      end
   endtask
   task automatic t_select;
      for (int i = 0; i < 5; i++) begin
         go(9'h018, 3'(i), 3'(i));
         chk("inSel", inSel, i);
         chk("outSel", outSel, i);
      end
      go(9'h030, 3'h2);
      chk("deselect", {inSel, outSel}, 6'h00);
      go(9'h040);
      chk("default", {inSel, outSel}, 6'h08);
      go(9'h004, 3'h0, 3'h0, 20'h003E8);
      chk("threshold", threshold, 20'h003E8);
   endtask
   task automatic host_tick(input logic [31:0] s);
      @(posedge sys_clk);
      syncEnable  <= 1'b1;
      hostSec     <= s;
      hostSecTick <= 1'b1;
      @(posedge sys_clk);
      hostSecTick <= 1'b0;
      #1;
   endtask
   task automatic t_resync;
      logic [31:0] r;
      r = stats.resyncs;
      host_tick(cardTime.sec + 32'h00000001);
      chk("no resync", stats.resyncs, r);
      host_tick(cardTime.sec + 32'h00000005);
      chk("resyncs", stats.resyncs, r + 1);
      chk("reload", cardTime.sec, hostSec);
      host_tick(cardTime.sec - 32'h00000003);
      chk("resyncs back", stats.resyncs, r + 2);
   endtask
   task automatic wait_rise;
      logic last;
      last = serialPulseIn;
      for (int k = 0; k < 2000; k++) begin
         @(posedge sys_clk);
         #1;
         if (serialPulseIn === 1'b1 && last === 1'b0) return;
         last = serialPulseIn;
      end
      failures++;
   endtask
   task automatic t_pulses;
      logic [31:0] t, b;
      @(posedge sys_clk);
      period <= 16'h03E8;
      for (int i = 0; i < 4; i++) begin
         t = stats.total;
         b = stats.bad;
         wait_rise;
         @(posedge sys_clk);
         #1;
         chk("total", stats.total, t + 1);
         chk("bad", stats.bad, b + (i == 3));
         chk("repeat", pulseOut, 1'b1);
         // First locked pulse: 1000 ticks of 8 ns are 8 us, about 431
         if (i == 1) chk("phase", phaseErr >= 27'sh0000420
                         && phaseErr <= 27'sh0000440, 1'b1);
         if (i == 1) chk("worst", stats.worstPhase, phaseErr);
         @(posedge sys_clk);
         if (i == 2) period <= 16'h0258;
      end
      period <= 16'h0000;
      // Error far above the threshold: never synced, so no loss counted
      chk("synced", synced, 1'b0);
      chk("failures", stats.failures, 32'h00000000);
   endtask
   task automatic t_clear;
      go(9'h002);
      chk("cleared", stats === '0, 1'b1);
      go(9'h018, 3'h2, 3'h3);
      @(posedge sys_clk);
      hostSec <= 32'h60000000;
      go(9'h080);
      chk("full sel", {inSel, outSel}, 6'h08);
      chk("full sec", cardTime.sec, 32'h60000000);
      go(9'h001);
      chk("load stats", stats === '0, 1'b1);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      do_reset;
      t_set;
      t_packet;
      t_select;
      t_resync;
      do_reset;
      // Selects are lost on a logic reload, so they go back in
      go(9'h018, 3'h1, 3'h1);
      t_pulses;
      t_clear;
      final_report;
   end
   // Run needs about 2800 cycles; seven times that means a hang
   initial begin
      tick(20000);
      failures++;
      final_report;
   end
endmodule // test_pstc_clock
`default_nettype wire
